// ==== logic/dorr_consts.vh ====
`ifndef DORR_CONSTS_VH
`define DORR_CONSTS_VH

// Drive actions
`define DORR_ACT_DEENERGIZE 2'h0
`define DORR_ACT_STOP 2'h1
`define DORR_ACT_OPEN 2'h2
`define DORR_ACT_CLOSE 2'h3

// Counts
`define DORR_CNT_NONE 16'h0000
`define DORR_CNT_UNLIMITED 16'hffff
`define DORR_RETRY_DEF 16'h0003
`define DORR_REV_DEF 16'h0000

// Times, ms
`define DORR_WAIT_MAX_MS 16'hea60
`define DORR_RETRY_WAIT_DEF_MS 16'h07d0
`define DORR_REV_WAIT_DEF_MS 16'h07d0
`define DORR_ON_DELAY_DEF_MS 16'h03e8

// Distances, mm
`define DORR_SUPP_CLOSED_DEF_MM 16'h000a
`define DORR_SUPP_OPEN_DEF_MM 16'h000a
`define DORR_SUPP_CREEP_DEF_MM 16'h0014
`define DORR_SUPP_LAST_DEF_MM 16'h0032
`define DORR_REV_DIST_DEF_MM 16'h0000

// Clock and tick
`define DORR_CLK_PERIOD_NS 10
`define DORR_MS_NS 1000000
`define DORR_CYC_PER_MS (`DORR_MS_NS / `DORR_CLK_PERIOD_NS)

// Drive order code for no order
`define DORR_ORDER_NONE 4'h0

`endif

// ==== logic/dorr_core.v ====
// Contract
// - After opening obstruction, retry configured times; 0 none, 0xffff unlimited.
// - Wait configured 0..60000 ms before each retry, default 2000.
// - During retry wait, deenergize (0) or hold stopped (1).
// - Retries exhausted, no reversing: apply after-retries drive action.
// - Up to configured reverses, each after a wait, over configured distance.
// - Obstruction during reverse applies its own drive action.
// - All reverses done: apply after-reverses drive action.
// - Ignore obstruction within set distance before open end while opening.
// - Ignore force obstruction within set distance before creep zone.
// - Ignore force obstruction within set distance after last obstruction.
// - Order on a level or inverted output acts only while that output is high.
// - Rise and fall outputs pulse exactly one cycle per input edge.
// - Orders on edge outputs are latched past the pulse.
// - Level output follows the input directly.
// - Inverted output follows the input inverted.
// - Opening detection armed only after switch-on delay.
// - Suppress detection for set distance after leaving closed end.
`timescale 1ns/100ps
`include "dorr_consts.vh"

module dorr_core #(
  parameter NIN = 5,
  parameter OW = 4,
  parameter CYC_PER_MS = `DORR_CYC_PER_MS
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Digital input pins
  input wire [NIN-1:0] din,
  // Order assignment per output, OW bits per input
  input wire [NIN*OW-1:0] rise_order_cfg,
  input wire [NIN*OW-1:0] fall_order_cfg,
  input wire [NIN*OW-1:0] level_order_cfg,
  input wire [NIN*OW-1:0] inv_order_cfg,
  input wire order_clear,
  // Function block outputs and resulting order
  output reg [NIN-1:0] in_rise_reg,
  output reg [NIN-1:0] in_fall_reg,
  output reg [NIN-1:0] in_level_reg,
  output reg [NIN-1:0] in_inv_reg,
  output reg [OW-1:0] drive_order_reg,
  // Movement status, same clock
  input wire open_move,
  input wire [15:0] pos_mm,
  input wire [15:0] closed_end_mm,
  input wire [15:0] open_end_mm,
  input wire [15:0] creep_start_mm,
  input wire obst_stop,
  input wire obst_force,
  // Obstruction configuration
  input wire [15:0] on_delay_ms,
  input wire [15:0] supp_closed_mm,
  input wire [15:0] supp_open_mm,
  input wire [15:0] supp_creep_mm,
  input wire [15:0] supp_last_mm,
  input wire [15:0] retry_count,
  input wire [15:0] retry_wait_ms,
  input wire retry_hold,
  input wire [1:0] retry_final,
  input wire [15:0] rev_count,
  input wire [15:0] rev_wait_ms,
  input wire [15:0] rev_dist_mm,
  input wire [1:0] rev_obst_action,
  input wire [1:0] rev_final,
  // Motor side
  output reg seq_active_reg,
  output reg [1:0] motor_cmd_reg,
  output reg [2:0] state_reg,
  output wire obst_hit
);

  localparam S_IDLE = 3'd0;
  localparam S_OPEN = 3'd1;
  localparam S_RWAIT = 3'd2;
  localparam S_VWAIT = 3'd3;
  localparam S_REV = 3'd4;
  localparam S_FINAL = 3'd5;

  // ==========================================================
  // Helpers
  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[16] ? 16'hffff : s[15:0];
    end
  endfunction

  function [15:0] sat_sub;
    input [15:0] a;
    input [15:0] b;
    begin
      sat_sub = (a > b) ? (a - b) : 16'h0000;
    end
  endfunction

  function [15:0] clamp_wait;
    input [15:0] t;
    begin
      clamp_wait = (t > `DORR_WAIT_MAX_MS) ? `DORR_WAIT_MAX_MS : t;
    end
  endfunction

  // Remaining budget of a bounded or unlimited count
  function left;
    input [15:0] used;
    input [15:0] cfg;
    begin
      left = (cfg == `DORR_CNT_UNLIMITED) || (used < cfg);
    end
  endfunction

  // ==========================================================
  // Input synchronisers and function block outputs
  reg [NIN-1:0] din_s1_reg;
  reg [NIN-1:0] din_s2_reg;
  reg [NIN-1:0] din_prev_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      din_s1_reg <= {NIN{1'b0}};
      din_s2_reg <= {NIN{1'b0}};
      din_prev_reg <= {NIN{1'b0}};
      in_rise_reg <= {NIN{1'b0}};
      in_fall_reg <= {NIN{1'b0}};
      in_level_reg <= {NIN{1'b0}};
      in_inv_reg <= {NIN{1'b0}};
    end else begin
      din_s1_reg <= din;
      din_s2_reg <= din_s1_reg;
      din_prev_reg <= din_s2_reg;
      in_rise_reg <= din_s2_reg & ~din_prev_reg;
      in_fall_reg <= ~din_s2_reg & din_prev_reg;
      in_level_reg <= din_s2_reg;
      in_inv_reg <= ~din_s2_reg;
    end
  end

  // ==========================================================
  // Drive order selection
  // Level orders win over latched ones; lower input index wins.
  reg [OW-1:0] latched_order_reg;
  reg [OW-1:0] edge_order;
  reg [OW-1:0] level_order;
  integer i;

  always @* begin
    edge_order = `DORR_ORDER_NONE;
    level_order = `DORR_ORDER_NONE;
    for (i = NIN - 1; i >= 0; i = i - 1) begin
      if (in_rise_reg[i] && rise_order_cfg[i*OW +: OW] != `DORR_ORDER_NONE) begin
        edge_order = rise_order_cfg[i*OW +: OW];
      end
      if (in_fall_reg[i] && fall_order_cfg[i*OW +: OW] != `DORR_ORDER_NONE) begin
        edge_order = fall_order_cfg[i*OW +: OW];
      end
      if (in_level_reg[i] && level_order_cfg[i*OW +: OW] != `DORR_ORDER_NONE) begin
        level_order = level_order_cfg[i*OW +: OW];
      end
      if (in_inv_reg[i] && inv_order_cfg[i*OW +: OW] != `DORR_ORDER_NONE) begin
        level_order = inv_order_cfg[i*OW +: OW];
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latched_order_reg <= `DORR_ORDER_NONE;
      drive_order_reg <= `DORR_ORDER_NONE;
    end else begin
      // A new edge beats a clear in the same cycle
      if (edge_order != `DORR_ORDER_NONE) begin
        latched_order_reg <= edge_order;
      end else if (order_clear) begin
        latched_order_reg <= `DORR_ORDER_NONE;
      end
      if (level_order != `DORR_ORDER_NONE) begin
        drive_order_reg <= level_order;
      end else if (edge_order != `DORR_ORDER_NONE) begin
        drive_order_reg <= edge_order;
      end else if (order_clear) begin
        drive_order_reg <= `DORR_ORDER_NONE;
      end else begin
        drive_order_reg <= latched_order_reg;
      end
    end
  end

  // ==========================================================
  // Millisecond tick
  // Restarted with the ms counter so a wait is never a tick short
  reg [31:0] div_reg;
  wire ms_restart;
  wire ms_tick = (div_reg == CYC_PER_MS - 1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 32'h00000000;
    end else begin
      div_reg <= (ms_tick || ms_restart) ? 32'h00000000 : div_reg + 32'h00000001;
    end
  end

  // ==========================================================
  // Detection windows
  reg [15:0] ms_reg;
  reg [15:0] last_obst_reg;
  reg last_valid_reg;
  reg [15:0] rev_start_reg;
  reg [15:0] retry_used_reg;
  reg [15:0] rev_used_reg;

  wire armed_time = (ms_reg >= on_delay_ms);
  wire past_closed = (pos_mm >= sat_add(closed_end_mm, supp_closed_mm));
  wire before_open = (pos_mm < sat_sub(open_end_mm, supp_open_mm));
  wire near_creep = (pos_mm >= sat_sub(creep_start_mm, supp_creep_mm)) &&
                    (pos_mm < creep_start_mm);
  wire near_last = last_valid_reg && (pos_mm >= last_obst_reg) &&
                   (pos_mm < sat_add(last_obst_reg, supp_last_mm));
  wire force_ok = obst_force && !near_creep && !near_last;
  wire opening_hit = (state_reg == S_OPEN) && armed_time && past_closed && before_open &&
                     (obst_stop || force_ok);
  wire rev_hit = (state_reg == S_REV) && (obst_stop || obst_force);
  wire rev_done = (rev_dist_mm == 16'h0000) ? (pos_mm <= closed_end_mm) :
                  (pos_mm <= sat_sub(rev_start_reg, rev_dist_mm));

  assign obst_hit = opening_hit || rev_hit;

  assign ms_restart = ((state_reg == S_IDLE) && open_move) ||
                      ((state_reg == S_OPEN) && opening_hit) ||
                      ((state_reg == S_RWAIT) && (ms_reg >= clamp_wait(retry_wait_ms))) ||
                      ((state_reg == S_REV) && !rev_hit && rev_done);

  // ==========================================================
  // Retry and reverse sequencer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      ms_reg <= 16'h0000;
      last_obst_reg <= 16'h0000;
      last_valid_reg <= 1'b0;
      rev_start_reg <= 16'h0000;
      retry_used_reg <= 16'h0000;
      rev_used_reg <= 16'h0000;
      seq_active_reg <= 1'b0;
      motor_cmd_reg <= `DORR_ACT_DEENERGIZE;
    end else begin
      if (ms_tick && ms_reg != 16'hffff) begin
        ms_reg <= ms_reg + 16'h0001;
      end
      case (state_reg)
        S_IDLE: begin
          seq_active_reg <= 1'b0;
          motor_cmd_reg <= `DORR_ACT_DEENERGIZE;
          retry_used_reg <= 16'h0000;
          rev_used_reg <= 16'h0000;
          last_valid_reg <= 1'b0;
          if (open_move) begin
            state_reg <= S_OPEN;
            ms_reg <= 16'h0000;
            motor_cmd_reg <= `DORR_ACT_OPEN;
          end
        end
        S_OPEN: begin
          if (opening_hit) begin
            last_obst_reg <= pos_mm;
            last_valid_reg <= 1'b1;
            seq_active_reg <= 1'b1;
            ms_reg <= 16'h0000;
            if (left(retry_used_reg, retry_count)) begin
              state_reg <= S_RWAIT;
              motor_cmd_reg <= retry_hold ? `DORR_ACT_STOP : `DORR_ACT_DEENERGIZE;
            end else if (left(rev_used_reg, rev_count)) begin
              state_reg <= S_VWAIT;
              motor_cmd_reg <= `DORR_ACT_STOP;
            end else if (rev_used_reg != 16'h0000) begin
              state_reg <= S_FINAL;
              motor_cmd_reg <= rev_final;
            end else begin
              state_reg <= S_FINAL;
              motor_cmd_reg <= retry_final;
            end
          end else if (!open_move && !seq_active_reg) begin
            state_reg <= S_IDLE;
          end else if (seq_active_reg && pos_mm >= open_end_mm) begin
            state_reg <= S_IDLE; // Retry or re-open reached the end
          end
        end
        S_RWAIT: begin
          if (ms_reg >= clamp_wait(retry_wait_ms)) begin
            state_reg <= S_OPEN;
            ms_reg <= 16'h0000;
            motor_cmd_reg <= `DORR_ACT_OPEN;
            if (retry_count != `DORR_CNT_UNLIMITED) begin
              retry_used_reg <= retry_used_reg + 16'h0001;
            end
          end
        end
        S_VWAIT: begin
          if (ms_reg >= clamp_wait(rev_wait_ms)) begin
            state_reg <= S_REV;
            rev_start_reg <= pos_mm;
            motor_cmd_reg <= `DORR_ACT_CLOSE;
            if (rev_count != `DORR_CNT_UNLIMITED) begin
              rev_used_reg <= rev_used_reg + 16'h0001;
            end
          end
        end
        S_REV: begin
          if (rev_hit) begin
            state_reg <= S_FINAL;
            motor_cmd_reg <= rev_obst_action;
          end else if (rev_done) begin
            // Open again; a further hit draws the next reverse, or the after-reverses action once all are used
            state_reg <= S_OPEN;
            ms_reg <= 16'h0000;
            motor_cmd_reg <= `DORR_ACT_OPEN;
          end
        end
        S_FINAL: begin
          // Final action holds until the movement request drops
          if (!open_move) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dorr_core

// ==== bench/dorr_core_assertions.sv ====
`timescale 1ns/100ps
// ==========
// Checker on the input outputs and the sequencer
module dorr_core_assertions #(
  parameter CYC_PER_MS = 10
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Inputs watched
  input wire [4:0] din,
  input wire retry_hold,
  input wire [15:0] retry_wait_ms,
  input wire [1:0] rev_obst_action,
  input wire [15:0] pos_mm,
  input wire [15:0] closed_end_mm,
  input wire [15:0] supp_closed_mm,
  // Outputs watched
  input wire [4:0] in_rise_reg,
  input wire [4:0] in_fall_reg,
  input wire [4:0] in_level_reg,
  input wire [4:0] in_inv_reg,
  input wire [1:0] motor_cmd_reg,
  input wire [2:0] state_reg,
  input wire obst_hit
);
  // Cycles spent in retry wait, judged on leaving it
  reg [31:0] wait_cnt_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt_reg <= 32'h0;
    end else begin
      wait_cnt_reg <= (state_reg == 3'h2) ? wait_cnt_reg + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rise; in_rise_reg == (in_level_reg & ~$past(in_level_reg)); endproperty
  a_rise: assert property (p_rise) else $error("rise pulse wrong");
  property p_fall; in_fall_reg == (~in_level_reg & $past(in_level_reg)); endproperty
  a_fall: assert property (p_fall) else $error("fall pulse wrong");
  property p_level; $past(rstn, 3) |-> in_level_reg == $past(din, 3); endproperty
  a_level: assert property (p_level) else $error("level lag wrong");
  property p_inv; $changed(in_level_reg) |-> in_inv_reg == ~in_level_reg; endproperty
  a_inv: assert property (p_inv) else $error("inverted output wrong");
  property p_hold; state_reg == 3'h2 |-> motor_cmd_reg == {1'b0, retry_hold}; endproperty
  a_hold: assert property (p_hold) else $error("retry wait drive wrong");
  property p_wait;
    $past(state_reg) == 3'h2 && state_reg != 3'h2 |->
      wait_cnt_reg + 32'h1 >= retry_wait_ms * CYC_PER_MS &&
      wait_cnt_reg <= retry_wait_ms * CYC_PER_MS + 2;
  endproperty
  a_wait: assert property (p_wait) else $error("retry wait length wrong");
  property p_rev;
    state_reg == 3'h3 ##1 state_reg == 3'h4 |-> motor_cmd_reg == 2'h3 && $past(motor_cmd_reg) == 2'h1;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse drive wrong");
  property p_rev_obst;
    state_reg == 3'h4 && obst_hit |=> state_reg == 3'h5 && motor_cmd_reg == $past(rev_obst_action);
  endproperty
  a_rev_obst: assert property (p_rev_obst) else $error("reverse obstruction wrong");
  property p_closed; state_reg == 3'h1 && pos_mm < closed_end_mm + supp_closed_mm |-> !obst_hit;
  endproperty
  a_closed: assert property (p_closed) else $error("hit near closed end");
endmodule // dorr_core_assertions

// ==== bench/dorr_motor_model.sv ====
`timescale 1ns/100ps
// ==========
// Door motor: 1 mm per MM_CYC cycles; coasts nowhere when not driven
module dorr_motor_model #(
  parameter MM_CYC = 2
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Drive and position
  input wire [1:0] motor_cmd,
  output reg [15:0] pos_mm
);
  integer div;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_mm <= 16'h0064;
      div <= 0;
    end else if (div < MM_CYC - 1) begin
      div <= div + 1;
    end else begin
      div <= 0;
      if (motor_cmd == 2'h2) pos_mm <= pos_mm + 16'h0001;
      if (motor_cmd == 2'h3) pos_mm <= pos_mm - 16'h0001;
    end
  end
endmodule // dorr_motor_model

// ==== bench/dorr_core_tb.sv ====
`timescale 1ns/100ps
// ==========
// Bench for the door obstruction sequencer
module dorr_core_tb;
  logic clk = 0, rstn = 0, order_clear = 0, open_move = 0, obst_stop = 0, obst_force = 0;
  logic retry_hold = 0;
  logic [4:0] din = 0;
  logic [19:0] rise_order_cfg = 0, fall_order_cfg = 0, level_order_cfg = 0, inv_order_cfg = 0;
  logic [15:0] closed_end_mm = 16'h0064, open_end_mm = 16'h03e8, creep_start_mm = 16'h0384;
  logic [15:0] on_delay_ms = 16'h0002, supp_closed_mm = 16'h000a, supp_open_mm = 16'h000a;
  logic [15:0] supp_creep_mm = 16'h0014, supp_last_mm = 16'h0032, retry_count = 0;
  logic [15:0] retry_wait_ms = 0, rev_count = 0, rev_wait_ms = 0, rev_dist_mm = 16'h0014;
  logic [1:0] retry_final = 0, rev_obst_action = 0, rev_final = 0;
  logic [3:0] r, f;
  wire [4:0] in_rise_reg, in_fall_reg, in_level_reg, in_inv_reg;
  wire [3:0] drive_order_reg;
  wire [1:0] motor_cmd_reg;
  wire [2:0] state_reg;
  wire [15:0] pos_mm;
  wire seq_active_reg, obst_hit;
  integer bad_count = 0, num_checks = 0, n, i, k;
  dorr_core #(.CYC_PER_MS(10)) DUT (.clk, .rstn, .din, .rise_order_cfg, .fall_order_cfg,
    .level_order_cfg, .inv_order_cfg, .order_clear, .in_rise_reg, .in_fall_reg, .in_level_reg,
    .in_inv_reg, .drive_order_reg, .open_move, .pos_mm, .closed_end_mm, .open_end_mm,
    .creep_start_mm, .obst_stop, .obst_force, .on_delay_ms, .supp_closed_mm, .supp_open_mm,
    .supp_creep_mm, .supp_last_mm, .retry_count, .retry_wait_ms, .retry_hold, .retry_final,
    .rev_count, .rev_wait_ms, .rev_dist_mm, .rev_obst_action, .rev_final, .seq_active_reg,
    .motor_cmd_reg, .state_reg, .obst_hit);
  dorr_motor_model #(.MM_CYC(2)) MOTOR (.clk, .rstn, .motor_cmd(motor_cmd_reg), .pos_mm);
  always #5 clk = ~clk;
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge, so no race with the design
  task cyc(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task wst(input logic [2:0] s);
    n = 0;
    while (state_reg !== s && n < 3000) begin
      cyc(1);
      n = n + 1;
    end
    if (n == 3000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  endtask
  task rst;
    rstn = 0;
    din = 0;
    open_move = 0;
    supp_closed_mm = 16'(5 + $urandom % 11);
    on_delay_ms = 16'(1 + $urandom % 3);
    open_end_mm = 16'(900 + $urandom % 100);
    creep_start_mm = open_end_mm - 16'h0064;
    cyc(3);
    rstn = 1;
  endtask
  function logic [3:0] code();
    code = 4'h1 + 4'($urandom % 7);
  endfunction
  task pin(input integer b, input logic val, input logic [3:0] exp);
    integer p;
    p = 0;
    din[b] = val;
    repeat (6) begin
      cyc(1);
      p = p + (val ? in_rise_reg[b] : in_fall_reg[b]);
    end
    chk(16'(p), 16'h0001);
    chk(in_level_reg[b], val);
    chk(in_inv_reg[b], !val);
    chk(drive_order_reg, exp);
  endtask
  task hit(input logic exp, input logic frc);
    obst_stop = !frc;
    obst_force = frc;
    #1;
    chk(obst_hit, exp);
    cyc(1);
    obst_stop = 0;
    obst_force = 0;
  endtask
  // Long enough for the switch-on delay and the closed-end zone
  task arm(input logic first);
    wst(3'h1);
    if (first) hit(1'b0, 1'b0);
    cyc(60);
  endtask
  initial begin
    n = $urandom(14);
    rst();
    for (i = 0; i < 5; i++) begin
      {rise_order_cfg, fall_order_cfg, level_order_cfg, inv_order_cfg} = 80'h0;
      order_clear = 1;
      cyc(1);
      order_clear = 0;
      r = code();
      f = code();
      rise_order_cfg[4*i +: 4] = r;
      fall_order_cfg[4*i +: 4] = f;
      pin(i, 1'b1, r);
      pin(i, 1'b0, f);
      level_order_cfg[4*i +: 4] = r | 4'h8;
      pin(i, 1'b1, r | 4'h8);
      pin(i, 1'b0, f);
      inv_order_cfg[4*i +: 4] = f | 4'h8;
      cyc(2);
      chk(drive_order_reg, f | 4'h8);
    end
    for (k = 0; k < 5; k++) begin
      rst();
      retry_count = (k == 4) ? 16'hffff : 16'(1 + k % 2);
      retry_hold = k[0];
      retry_final = k[1:0];
      rev_count = 0;
      retry_wait_ms = 16'($urandom % 3);
      open_move = 1;
      for (i = 0; i < 3; i++) begin
        arm(i == 0);
        hit(1'b1, 1'b0);
        chk(state_reg, (i < retry_count) ? 3'h2 : 3'h5);
        chk(motor_cmd_reg, (i < retry_count) ? {1'b0, retry_hold} : retry_final);
        if (state_reg === 3'h5) break;
      end
    end
    for (k = 0; k < 8; k++) begin
      rst();
      retry_count = 0;
      rev_count = 1;
      rev_obst_action = k[1:0];
      rev_final = ~k[1:0];
      rev_wait_ms = 16'($urandom % 3);
      open_move = 1;
      arm(1'b0);
      hit(1'b1, 1'b0);
      chk(state_reg, 3'h3);
      chk(motor_cmd_reg, 2'h1);
      wst(3'h4);
      chk(motor_cmd_reg, 2'h3);
      if (k[2]) begin
        cyc(4);
        hit(1'b1, 1'b1);
        chk(motor_cmd_reg, rev_obst_action);
      end else begin
        arm(1'b0);
        hit(1'b0, 1'b1);
        hit(1'b1, 1'b0);
        chk(motor_cmd_reg, rev_final);
      end
      chk(state_reg, 3'h5);
      chk(seq_active_reg, 1'b1);
    end
    give_verdict();
  end
endmodule // dorr_core_tb
bind dorr_core dorr_core_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clk, .rstn, .din,
  .retry_hold, .retry_wait_ms, .rev_obst_action, .pos_mm, .closed_end_mm, .supp_closed_mm,
  .in_rise_reg, .in_fall_reg, .in_level_reg, .in_inv_reg, .motor_cmd_reg, .state_reg,
  .obst_hit);
